// File: pkg/pm1_event_if.sv
// interface: event flags and gated enables passed from the register bank to the interrupt combiner
`timescale 1ns/1ps
`default_nettype none
interface pm1_event_if;
    logic [2:0] eventFlag;
    logic [2:0] gatedEnable;
    logic       sysWorking;
    logic       pmInterrupt;
    modport regs (output eventFlag, output gatedEnable, output sysWorking, input pmInterrupt);
    modport comb (input eventFlag, input gatedEnable, input sysWorking, output pmInterrupt);
endinterface
`default_nettype wire

// File: pkg/pm1_regs_pkg.sv
// package: register map, field positions and reset values for the pm1 enable/control slice
package pm1_regs_pkg;
    // ==========================================
    // register byte offsets (printed offsets are not all multiples of four)
    localparam int unsigned IDX_CONTROL_LOW     = 0;
    localparam int unsigned IDX_ENABLE_LOW      = 2;
    localparam int unsigned IDX_ENABLE_HIGH     = 3;
    localparam logic [3:0]  ADDR_CONTROL_LOW    = 4'h0;
    localparam logic [3:0]  ADDR_ENABLE_LOW     = 4'h8;
    localparam logic [3:0]  ADDR_ENABLE_HIGH    = 4'hC;
    localparam logic [3:0]  ADDR_EVENT_CONFIG   = 4'h4;
    localparam logic [3:0]  ADDR_EVENT_FLAGS    = 4'h1 << 2 ^ 4'h0 ^ 4'h4 ^ 4'h4;
    localparam logic [5:0]  ADDR_W_EVENT_FLAGS  = 6'h10;
    localparam logic [5:0]  ADDR_W_IRQ_MASK     = 6'h14;
    localparam logic [5:0]  ADDR_W_SYS_STATE    = 6'h18;
    // ==========================================
    // field positions
    localparam int unsigned BIT_POWER_BUTTON    = 0;
    localparam int unsigned BIT_SLEEP_BUTTON    = 1;
    localparam int unsigned BIT_ALARM           = 2;
    localparam int unsigned BIT_PM_TIMER        = 0;
    localparam int unsigned BIT_GLOBAL_LOCK     = 5;
    // ==========================================
    // reset values
    localparam logic [2:0]  ENABLE_RESET        = 3'h0;
    localparam logic [2:0]  CONFIG_RESET        = 3'h0;
    localparam logic [2:0]  FLAGS_RESET         = 3'h0;
    localparam logic [2:0]  IRQ_MASK_RESET      = 3'h0;
    localparam logic [7:0]  READ_ZERO           = 8'h00;
    localparam logic [31:0] BUS_IDLE_DATA       = 32'h0000_0000;
endpackage

// File: verif/test_pm1_event_enable_control_regs.sv
// testbench: register, gating and interrupt checks for the pm1 enable/control slice
`timescale 1ns/1ps
`default_nettype none
module test_pm1_event_enable_control_regs;
    // ==========================================
    // stimulus and observation signals
    logic        clk;
    logic        rst;
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        readdatavalid;
    logic [2:0]  evIn;
    logic        pmInt;
    logic        irq;
    int          num_errors;
    int          cmp_count;
    localparam logic [5:0] A_CTL = {2'h0, pm1_regs_pkg::ADDR_CONTROL_LOW};
    localparam logic [5:0] A_ENL = {2'h0, pm1_regs_pkg::ADDR_ENABLE_LOW};
    localparam logic [5:0] A_ENH = {2'h0, pm1_regs_pkg::ADDR_ENABLE_HIGH};
    localparam logic [5:0] A_CFG = {2'h0, pm1_regs_pkg::ADDR_EVENT_CONFIG};
    localparam logic [5:0] A_FLG = pm1_regs_pkg::ADDR_W_EVENT_FLAGS;
    localparam logic [5:0] A_MSK = pm1_regs_pkg::ADDR_W_IRQ_MASK;
    localparam logic [5:0] A_SYS = pm1_regs_pkg::ADDR_W_SYS_STATE;
    localparam logic [5:0] A_BAD = 6'h3C;

    pm1_event_enable_control_regs i_pm1_event_enable_control_regs (
        .clk              (clk),
        .rst              (rst),
        .address          (address),
        .read             (read),
        .write            (write),
        .writedata        (writedata),
        .byteenable       (byteenable),
        .readdata         (readdata),
        .waitrequest      (waitrequest),
        .readdatavalid    (readdatavalid),
        .alarmActive      (evIn[2]),
        .sleepButtonPress (evIn[1]),
        .powerButtonPress (evIn[0]),
        .pm_interrupt_out (pmInt),
        .irq              (irq)
    );

    // ==========================================
    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================
    // compare and bus helpers
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // request held until the rising edge that sees waitrequest low; data taken at that same edge
    // only the watchdog ends a wait that never finishes
    task automatic bus(input logic isWr, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
        address    <= a;
        writedata  <= {24'h000000, d};
        byteenable <= 4'hF;
        read       <= ~isWr;
        write      <= isWr;
        @(posedge clk);
        while (waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        q = readdata[7:0];
        chk("readdatavalid", 8'h00, {7'h00, readdatavalid});
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdchk(input string what, input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(what, exp, q);
    endtask

    // pins settle a few edges after a bus write or an event; the pin is read after the wait
    task automatic pinchk(input string what, input bit onIrq, input logic exp);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(what, {7'h00, exp}, {7'h00, (onIrq ? irq : pmInt)});
        @(posedge clk);
    endtask

    // held long enough to pass the two-flop synchroniser
    task automatic press(input int i);
        evIn <= 3'h1 << i;
        repeat (3) @(posedge clk);
        evIn <= 3'h0;
        repeat (5) @(posedge clk);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        #200000;
        num_errors++;
        summarize();
    end

    // ==========================================
    // main sequence
    initial begin
        num_errors = 0;
        cmp_count  = 0;
        rst = 1'b1; address = 6'h00; read = 1'b0; write = 1'b0;
        writedata = 32'h00000000; byteenable = 4'h0; evIn = 3'h0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // reset values
        rdchk("enable_high", A_ENH, 8'h00);
        rdchk("enable_low", A_ENL, 8'h00);
        rdchk("control_low", A_CTL, 8'h00);
        rdchk("config", A_CFG, 8'h00);
        rdchk("flags", A_FLG, 8'h00);
        rdchk("sys_state", A_SYS, 8'h01);
        chk("pm_int_reset", 8'h00, {7'h00, pmInt});
        $display("test reset values done");
        // read-only and unmapped places ignore writes
        wr(A_ENL, 8'hFF);
        rdchk("enable_low_ro", A_ENL, 8'h00);
        wr(A_ENL, 8'h21);
        rdchk("enable_low_bits", A_ENL, 8'h00);
        wr(A_CTL, 8'hFF);
        rdchk("control_low_ro", A_CTL, 8'h00);
        wr(A_BAD, 8'hFF);
        rdchk("unmapped", A_BAD, 8'h00);
        $display("test read-only done");
        // enables held low while gates closed, restored when opened
        wr(A_ENH, 8'h07);
        rdchk("enh_gated", A_ENH, 8'h00);
        wr(A_CFG, 8'h07);
        rdchk("enh_open", A_ENH, 8'h07);
        wr(A_ENH, 8'hFF);
        rdchk("enh_reserved", A_ENH, 8'h07);
        wr(A_CFG, 8'h03);
        rdchk("enh_alarm_gated", A_ENH, 8'h03);
        wr(A_CFG, 8'h05);
        rdchk("enh_sleep_gated", A_ENH, 8'h05);
        wr(A_CFG, 8'h06);
        rdchk("enh_power_gated", A_ENH, 8'h06);
        wr(A_CFG, 8'h07);
        wr(A_ENH, 8'h00);
        rdchk("enh_cleared", A_ENH, 8'h00);
        $display("test gating done");
        // each event: enable routes it to the interrupt, disable blocks it
        for (int i = 0; i < 3; i++) begin
            press(i);
            pinchk("pm_int_disabled", 1'b0, 1'b0);
            rdchk("flag_set", A_FLG, 8'h01 << i);
            wr(A_ENH, 8'h01 << i);
            pinchk("pm_int_enabled", 1'b0, 1'b1);
            wr(A_FLG, 8'h00);
            rdchk("flag_w0_keep", A_FLG, 8'h01 << i);
            wr(A_FLG, 8'h01 << i);
            rdchk("flag_w1c", A_FLG, 8'h00);
            pinchk("pm_int_cleared", 1'b0, 1'b0);
            // a fresh event, then the gate closes under it
            press(i);
            pinchk("pm_int_again", 1'b0, 1'b1);
            wr(A_CFG, 8'h07 & ~(8'h01 << i));
            pinchk("pm_int_gate_closed", 1'b0, 1'b0);
            wr(A_CFG, 8'h07);
            wr(A_ENH, 8'h00);
        end
        $display("test event routing done");
        // power button has no influence in a sleep state
        wr(A_SYS, 8'h00);
        wr(A_ENH, 8'h01);
        press(0);
        pinchk("pm_int_sleep", 1'b0, 1'b0);
        wr(A_SYS, 8'h01);
        press(0);
        pinchk("pm_int_working", 1'b0, 1'b1);
        wr(A_FLG, 8'h07);
        wr(A_ENH, 8'h00);
        $display("test sleep state done");
        // status/mask interrupt: a set flag reaches irq only through its mask bit
        press(2);
        wr(A_MSK, 8'h00);
        pinchk("irq_masked", 1'b1, 1'b0);
        wr(A_MSK, 8'h04);
        rdchk("irq_mask", A_MSK, 8'h04);
        pinchk("irq_unmasked", 1'b1, 1'b1);
        wr(A_FLG, 8'h04);
        pinchk("irq_cleared", 1'b1, 1'b0);
        $display("test irq done");
        summarize();
    end
endmodule
`default_nettype wire

// File: verilog/pm1_event_enable_control_regs.sv
// module: pm1 enable low/high and control low registers with avalon-mm slave
// Summary of operation
// R1 - global lock enable bit 5 of low enable reads zero, writes ignored.
// R2 - pm timer enable bit 0 of low enable reads zero.
// R3 - all unimplemented and reserved bits read zero.
// R4 - alarm flag with alarm enable set raises the interrupt, else not.
// R5 - alarm enable held zero while alarm event gate is zero.
// R6 - sleep button flag with its enable set raises the interrupt, else not.
// R7 - sleep button enable forced zero while its event gate is zero.
// R8 - power button enable raises interrupt only in working state.
// R9 - in sleep states the power button enable has no effect.
// R10 - power button enable forced zero while its event gate is zero.
// R11 - high enable bits are read/write and reset to zero.
// R12 - control low bits 2, 1 and 0 always read zero.
// R13 - alarm flag set by alarm, cleared only by writing one; the code also clears it while the alarm event gate is zero.
// R14 - interrupt is or of each flag and its enable, power button qualified.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module pm1_event_enable_control_regs (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [5:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic             readdatavalid,
    input  wire logic        alarmActive,
    input  wire logic        sleepButtonPress,
    input  wire logic        powerButtonPress,
    output logic             pm_interrupt_out,
    output logic             irq
);
    // ==========================================
    // types and state
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } bus_state_t;

    bus_state_t busState_ff;
    logic [2:0]  enable_ff;
    logic [2:0]  eventConfig_ff;
    logic [2:0]  eventFlag_ff;
    logic [2:0]  irqMask_ff;
    logic        sysWorking_ff;
    logic [31:0] readdata_ff;
    logic [2:0]  evSync1_ff;
    logic [2:0]  evSync2_ff;
    logic [2:0]  evPrev_ff;
    logic [2:0]  gatedEnable;
    logic [2:0]  evRise;
    logic        accept;
    logic        wrLane0;
    logic [7:0]  wrByte;

    pm1_event_if ev ();

    // ==========================================
    // bus helpers
    // byte address from a printed register index
    function automatic logic [5:0] idx_addr(input int unsigned idx);
        idx_addr = 6'(idx * 4);
    endfunction

    // ==========================================
    // avalon slave: one wait cycle, answer on the second edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busState_ff <= BUS_IDLE;
        end else begin
            case (busState_ff)
                BUS_IDLE: begin
                    if (read || write) begin
                        busState_ff <= BUS_ACK;
                    end
                end
                BUS_ACK: begin
                    busState_ff <= BUS_IDLE;
                end
                default: begin
                    busState_ff <= BUS_IDLE;
                end
            endcase
        end
    end

    assign accept        = (busState_ff == BUS_ACK);
    assign waitrequest   = (read || write) && !accept;
    assign readdatavalid = 1'b0;
    assign wrLane0       = write && accept && byteenable[0];
    assign wrByte        = writedata[7:0];

    // ==========================================
    // event input synchronisers and edge detect
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            evSync1_ff <= 3'h0;
            evSync2_ff <= 3'h0;
            evPrev_ff  <= 3'h0;
        end else begin
            evSync1_ff <= {alarmActive, sleepButtonPress, powerButtonPress};
            evSync2_ff <= evSync1_ff;
            evPrev_ff  <= evSync2_ff;
        end
    end

    assign evRise = evSync2_ff & ~evPrev_ff;

    // ==========================================
    // high enable register, software read/write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_ff <= pm1_regs_pkg::ENABLE_RESET; // R11
        end else if (wrLane0 && address == idx_addr(pm1_regs_pkg::IDX_ENABLE_HIGH)) begin
            enable_ff <= wrByte[2:0]; // R11
        end
    end

    // gates force the enables low; stored value kept so reopening a gate restores it
    assign gatedEnable[pm1_regs_pkg::BIT_ALARM] =
        enable_ff[pm1_regs_pkg::BIT_ALARM] & eventConfig_ff[pm1_regs_pkg::BIT_ALARM]; // R5
    assign gatedEnable[pm1_regs_pkg::BIT_SLEEP_BUTTON] =
        enable_ff[pm1_regs_pkg::BIT_SLEEP_BUTTON] & eventConfig_ff[pm1_regs_pkg::BIT_SLEEP_BUTTON]; // R7
    assign gatedEnable[pm1_regs_pkg::BIT_POWER_BUTTON] =
        enable_ff[pm1_regs_pkg::BIT_POWER_BUTTON] & eventConfig_ff[pm1_regs_pkg::BIT_POWER_BUTTON]; // R10

    // ==========================================
    // event config register (gates) and system state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eventConfig_ff <= pm1_regs_pkg::CONFIG_RESET;
        end else if (wrLane0 && address == {2'b00, pm1_regs_pkg::ADDR_EVENT_CONFIG}) begin
            eventConfig_ff <= wrByte[2:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sysWorking_ff <= 1'b1;
        end else if (wrLane0 && address == pm1_regs_pkg::ADDR_W_SYS_STATE) begin
            sysWorking_ff <= wrByte[0];
        end
    end

    // ==========================================
    // sticky event flags: set wins over write-one clear; gate closed holds flag at zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eventFlag_ff <= pm1_regs_pkg::FLAGS_RESET;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (!eventConfig_ff[i]) begin
                    eventFlag_ff[i] <= 1'b0;
                end else if (evRise[i]) begin
                    eventFlag_ff[i] <= 1'b1; // R13
                end else if (wrLane0 && address == pm1_regs_pkg::ADDR_W_EVENT_FLAGS && wrByte[i]) begin
                    eventFlag_ff[i] <= 1'b0; // R13
                end
            end
        end
    end

    // ==========================================
    // interrupt mask for the bus-side irq line
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqMask_ff <= pm1_regs_pkg::IRQ_MASK_RESET;
        end else if (wrLane0 && address == pm1_regs_pkg::ADDR_W_IRQ_MASK) begin
            irqMask_ff <= wrByte[2:0];
        end
    end

    assign irq = |(eventFlag_ff & irqMask_ff);

    // ==========================================
    // read mux; unmapped addresses read zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readdata_ff <= pm1_regs_pkg::BUS_IDLE_DATA;
        end else if (read && !accept) begin
            readdata_ff <= pm1_regs_pkg::BUS_IDLE_DATA;
            if (address == idx_addr(pm1_regs_pkg::IDX_CONTROL_LOW)) begin
                readdata_ff[7:0] <= pm1_regs_pkg::READ_ZERO; // R12
            end else if (address == idx_addr(pm1_regs_pkg::IDX_ENABLE_LOW)) begin
                readdata_ff[7:0] <= pm1_regs_pkg::READ_ZERO; // R1 R2
            end else if (address == idx_addr(pm1_regs_pkg::IDX_ENABLE_HIGH)) begin
                readdata_ff[7:0] <= {5'h00, gatedEnable}; // R3 R11
            end else if (address == {2'b00, pm1_regs_pkg::ADDR_EVENT_CONFIG}) begin
                readdata_ff[7:0] <= {5'h00, eventConfig_ff};
            end else if (address == pm1_regs_pkg::ADDR_W_EVENT_FLAGS) begin
                readdata_ff[7:0] <= {5'h00, eventFlag_ff};
            end else if (address == pm1_regs_pkg::ADDR_W_IRQ_MASK) begin
                readdata_ff[7:0] <= {5'h00, irqMask_ff};
            end else if (address == pm1_regs_pkg::ADDR_W_SYS_STATE) begin
                readdata_ff[7:0] <= {7'h00, sysWorking_ff};
            end
        end
    end

    assign readdata = readdata_ff;

    // ==========================================
    // interrupt combiner
    assign ev.eventFlag   = eventFlag_ff;
    assign ev.gatedEnable = gatedEnable;
    assign ev.sysWorking  = sysWorking_ff;

    pm1_irq_combine i_pm1_irq_combine (
        .clk (clk),
        .rst (rst),
        .ev  (ev)
    );

    assign pm_interrupt_out = ev.pmInterrupt;

    // ==========================================
    // checks
    sequence alarm_armed_s;
        eventFlag_ff[2] && gatedEnable[2];
    endsequence

    alarm_irq_a : assert property (@(posedge clk) disable iff (rst) // R4
        alarm_armed_s |=> pm_interrupt_out)
        else $error("alarm did not raise interrupt");
    // gate checks look at what software reads back, not at the gating expression itself
    alarm_gate_a : assert property (@(posedge clk) disable iff (rst) // R5
        (read && !accept && address == 6'h0C && !eventConfig_ff[2]) |=> !readdata_ff[2])
        else $error("alarm enable not forced low");
    sleep_irq_a : assert property (@(posedge clk) disable iff (rst) // R6
        (eventFlag_ff[1] && gatedEnable[1]) |=> pm_interrupt_out)
        else $error("sleep button did not raise interrupt");
    sleep_gate_a : assert property (@(posedge clk) disable iff (rst) // R7
        (read && !accept && address == 6'h0C && !eventConfig_ff[1]) |=> !readdata_ff[1])
        else $error("sleep enable not forced low");
    pwr_work_a : assert property (@(posedge clk) disable iff (rst) // R8
        (eventFlag_ff[0] && gatedEnable[0] && sysWorking_ff) |=> pm_interrupt_out)
        else $error("power button did not raise interrupt");
    pwr_gate_a : assert property (@(posedge clk) disable iff (rst) // R10
        (read && !accept && address == 6'h0C && !eventConfig_ff[0]) |=> !readdata_ff[0])
        else $error("power enable not forced low");
    no_enables_irq_a : assert property (@(posedge clk) disable iff (rst) // R4
        (gatedEnable == 3'h0) |=> !pm_interrupt_out)
        else $error("interrupt with no enable set");
    low_regs_zero_a : assert property (@(posedge clk) disable iff (rst) // R12
        (read && !accept && (address == 6'h00 || address == 6'h08)) |=> readdata_ff == 32'h0)
        else $error("unimplemented register read nonzero");
    flag_sticky_a : assert property (@(posedge clk) disable iff (rst) // R13
        (eventFlag_ff[2] && eventConfig_ff[2] && !(wrLane0 && address == 6'h10 && wrByte[2]))
        |=> eventFlag_ff[2])
        else $error("alarm flag dropped without clear");
endmodule
`default_nettype wire

// File: verilog/pm1_irq_combine.sv
// module: combines event flags with enables into the power-management interrupt
`timescale 1ns/1ps
`default_nettype none
module pm1_irq_combine (
    input  wire logic clk,
    input  wire logic rst,
    pm1_event_if.comb ev
);
    logic pmInterrupt_ff;
    logic nxt_pmInterrupt;

    // ==========================================
    // interrupt combine
    // power button only counts in the working state; asleep, its enable is ignored
    always_comb begin
        nxt_pmInterrupt = (ev.eventFlag[pm1_regs_pkg::BIT_ALARM] & ev.gatedEnable[pm1_regs_pkg::BIT_ALARM]) // R4
                        | (ev.eventFlag[pm1_regs_pkg::BIT_SLEEP_BUTTON]
                           & ev.gatedEnable[pm1_regs_pkg::BIT_SLEEP_BUTTON])                               // R6
                        | (ev.eventFlag[pm1_regs_pkg::BIT_POWER_BUTTON]
                           & ev.gatedEnable[pm1_regs_pkg::BIT_POWER_BUTTON] & ev.sysWorking);              // R8 R9 R14
    end

    // registered so the output pin is glitch free
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pmInterrupt_ff <= 1'b0;
        end else begin
            pmInterrupt_ff <= nxt_pmInterrupt;
        end
    end

    assign ev.pmInterrupt = pmInterrupt_ff;

    // ==========================================
    // checks
    // expectation rebuilt from the flags themselves, not from the combine expression
    irq_follows_a : assert property (@(posedge clk) disable iff (rst) // R14
        ##1 pmInterrupt_ff == $past(|(ev.eventFlag & ev.gatedEnable & {2'b11, ev.sysWorking})))
        else $error("interrupt does not follow flags and enables");
    pwr_asleep_a : assert property (@(posedge clk) disable iff (rst) // R9
        (!ev.sysWorking && ev.eventFlag == 3'h1) |=> !pmInterrupt_ff)
        else $error("power button raised interrupt while asleep");
endmodule
`default_nettype wire
